/* File: inc/hap_pkg.sv */
// Package: constants, register map and types for the homing and analogue position block
// Assumes: APB slave at 32-bit data, pclk at 250 MHz
package hap_pkg;
	// ==========================================================
	// Clock and time
	localparam int unsigned CLK_MHZ         = 250;
	localparam int unsigned MS_US           = 1000;
	localparam int unsigned CYC_PER_MS      = CLK_MHZ * MS_US;
	localparam int unsigned POS_W           = 32;
	localparam int unsigned ADC_W           = 16;
	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [11:0] CTRL_OFS        = 12'h000;
	localparam logic [11:0] STAT_OFS        = 12'h004;
	localparam logic [11:0] HVEL_OFS        = 12'h008;
	localparam logic [11:0] HACC_OFS        = 12'h00C;
	localparam logic [11:0] OFFS_OFS        = 12'h010;
	localparam logic [11:0] STROKE_OFS      = 12'h014;
	localparam logic [11:0] TMIN_OFS        = 12'h018;
	localparam logic [11:0] TMAX_OFS        = 12'h01C;
	localparam logic [11:0] DBZ_OFS         = 12'h020;
	localparam logic [11:0] DBS_OFS         = 12'h024;
	localparam logic [11:0] FILT_OFS        = 12'h028;
	localparam logic [11:0] FMIN_OFS        = 12'h02C;
	localparam logic [11:0] FMAX_OFS        = 12'h030;
	localparam logic [11:0] POS_OFS         = 12'h034;
	localparam logic [11:0] TGT_OFS         = 12'h038;
	localparam logic [11:0] FBP_OFS         = 12'h03C;
	// ==========================================================
	// Control fields
	localparam int unsigned CTRL_METH_LSB   = 0;
	localparam int unsigned CTRL_START_BIT  = 4;
	localparam int unsigned CTRL_GOZERO_BIT = 5;
	localparam int unsigned CTRL_ABSMV_BIT  = 6;
	localparam int unsigned CTRL_NOFB_BIT   = 7;
	// ==========================================================
	// Reset values
	localparam logic [31:0] HVEL_RST        = 32'h0000_0010;
	localparam logic [31:0] HACC_RST        = 32'h0000_00A0;
	localparam logic [15:0] TMAX_RST        = 16'h2710;
	localparam logic [15:0] DBZ_RST         = 16'h0064;
	localparam logic [15:0] DBS_RST         = 16'h000A;
	localparam logic [15:0] FILT_RST        = 16'h000A;
	localparam logic [15:0] FMAX_RST        = 16'h2710;
	localparam logic [31:0] STROKE_RST      = 32'h0000_0064;
	// ==========================================================
	// Homing methods
	typedef enum logic [2:0] {
		HOME_AT_CURRENT_POSITION   = 3'h0,
		HOME_NEGATIVE_SWITCH       = 3'h1,
		HOME_POSITIVE_SWITCH       = 3'h2,
		HOME_INDEX_NEGATIVE_SEARCH = 3'h3,
		HOME_INDEX_POSITIVE_SEARCH = 3'h4,
		HOME_ANALOG_ABSOLUTE       = 3'h5
	} hap_method_e;
	// Homing sequencer, one-hot
	typedef enum logic [5:0] {
		ST_IDLE   = 6'b000001,
		ST_SEARCH = 6'b000010,
		ST_BRAKE  = 6'b000100,
		ST_LEAVE  = 6'b001000,
		ST_SETTLE = 6'b010000,
		ST_DONE   = 6'b100000
	} hap_state_e;
endpackage

/* File: rtl/hap_sync.sv */
// Two-flop synchroniser for a bus of pin levels
// Assumes: inputs asynchronous to pclk
`timescale 1ns/1ps
module hap_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;
	// ==========================================================
	// First flop feeds only the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= '0;
			q        <= '0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule

/* File: rtl/hap_avg.sv */
// Moving block average of a signed sample over a window of win_ms milliseconds, one sample per ms
// Assumes: sample is synchronised to pclk
`timescale 1ns/1ps
module hap_avg #(
	parameter int unsigned W = 16
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic signed [W-1:0] sample,
	input  wire logic [15:0]         win_ms,
	input  wire logic [31:0]         cyc_per_ms,
	output logic signed [W-1:0]      avg
);
	logic [31:0]             ms_cnt_reg;
	logic [15:0]             ms_reg;
	logic [15:0]             n_reg;
	logic signed [W+15:0]    acc_reg;
	logic                    tick;
	logic [15:0]             div_n;
	assign tick  = (ms_cnt_reg >= cyc_per_ms - 32'h1);
	// Samples in the window are the stored ones plus the one arriving now
	assign div_n = n_reg + 16'h1;
	// ==========================================================
	// Millisecond tick; one sample per ms keeps the divider small
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_cnt_reg <= '0;
		end else begin
			ms_cnt_reg <= tick ? 32'h0 : ms_cnt_reg + 32'h1;
		end
	end
	// ==========================================================
	// Accumulate over the window, then publish the mean
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_reg  <= '0;
			n_reg   <= '0;
			acc_reg <= '0;
			avg     <= '0;
		end else if (tick) begin
			if (ms_reg + 16'h1 >= win_ms) begin
				avg     <= W'((acc_reg + (W+16)'(sample)) / $signed({1'b0, div_n}));
				acc_reg <= '0;
				n_reg   <= '0;
				ms_reg  <= '0;
			end else begin
				acc_reg <= acc_reg + (W+16)'(sample);
				n_reg   <= n_reg + 16'h1;
				ms_reg  <= ms_reg + 16'h1;
			end
		end
	end
endmodule

/* File: rtl/hap_top.sv */
// Homing sequencer, coordinate zero/offset and analogue position scaling
// Assumes: APB master on pclk; pins and ADC words arrive asynchronously
`timescale 1ns/1ps
module hap_top
	import hap_pkg::*;
(
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [11:0]        paddr,
	input  wire logic [31:0]        pwdata,
	input  wire logic               local_ui_sel,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic               fieldbus_active,
	input  wire logic               drive_enable_input,
	input  wire logic               positive_limit_input,
	input  wire logic               negative_limit_input,
	input  wire logic               encoder_index,
	input  wire logic               drive_error,
	input  wire logic               axis_standstill,
	input  wire logic signed [31:0] actual_position,
	input  wire logic signed [15:0] target_analog_input,
	input  wire logic signed [15:0] feedback_analog_input,
	output logic                    move_req,
	output logic                    move_dir_neg,
	output logic                    stop_req,
	output logic [31:0]             move_vel,
	output logic [31:0]             move_acc,
	output logic                    abs_move_req,
	output logic signed [31:0]      abs_target,
	output logic                    referenced
);
	import hap_pkg::*;
	// ==========================================================
	// Pin and ADC word synchronisers
	logic [3:0] pins_s;
	hap_sync #(.W(4)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       ({drive_enable_input, positive_limit_input,
		           negative_limit_input, encoder_index}),
		.q       (pins_s)
	);
	logic en_s, lim_pos_s, lim_neg_s, idx_s;
	assign {en_s, lim_pos_s, lim_neg_s, idx_s} = pins_s;
	logic [15:0] tgt_s, fb_s;
	hap_sync #(.W(32)) u_sync_adc (
		.pclk    (pclk),
		.presetn (presetn),
		.d       ({target_analog_input, feedback_analog_input}),
		.q       ({tgt_s, fb_s})
	);
	// ==========================================================
	// Registers
	logic [2:0]         meth_reg;
	logic               absmv_reg;
	logic               nofb_reg;
	logic [31:0]        hvel_reg;
	logic [31:0]        hacc_reg;
	logic signed [31:0] offs_reg;
	logic signed [31:0] stroke_reg;
	logic signed [15:0] tmin_reg, tmax_reg, fmin_reg, fmax_reg;
	logic [15:0]        dbz_reg, dbs_reg, filt_reg;
	logic signed [31:0] zero_reg;
	logic signed [31:0] tgt_pos_reg, fb_pos_reg;
	logic               start_pulse, gozero_pulse;
	hap_state_e         st_reg;
	logic               wr_acc, rd_acc, wr_ok;
	assign wr_acc = psel && penable && pwrite;
	assign rd_acc = psel && penable && !pwrite;
	assign wr_ok  = wr_acc && !(fieldbus_active && local_ui_sel);
	assign start_pulse  = wr_ok && paddr == CTRL_OFS && pwdata[CTRL_START_BIT];
	assign gozero_pulse = wr_ok && paddr == CTRL_OFS && pwdata[CTRL_GOZERO_BIT];
	// ==========================================================
	// Parameter writes; locked out for local writes while the bus rules
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meth_reg   <= '0;
			absmv_reg  <= 1'b0;
			nofb_reg   <= 1'b1;
			hvel_reg   <= HVEL_RST;
			hacc_reg   <= HACC_RST;
			offs_reg   <= '0;
			stroke_reg <= STROKE_RST;
			tmin_reg   <= '0;
			tmax_reg   <= TMAX_RST;
			dbz_reg    <= DBZ_RST;
			dbs_reg    <= DBS_RST;
			filt_reg   <= FILT_RST;
			fmin_reg   <= '0;
			fmax_reg   <= FMAX_RST;
		end else if (wr_ok) begin
			unique case (paddr)
				CTRL_OFS: begin
					meth_reg  <= pwdata[CTRL_METH_LSB +: 3];
					absmv_reg <= pwdata[CTRL_ABSMV_BIT];
					nofb_reg  <= pwdata[CTRL_NOFB_BIT];
				end
				HVEL_OFS:   hvel_reg   <= pwdata;
				HACC_OFS:   hacc_reg   <= pwdata;
				OFFS_OFS:   offs_reg   <= pwdata;
				STROKE_OFS: stroke_reg <= pwdata;
				TMIN_OFS:   tmin_reg   <= pwdata[15:0];
				TMAX_OFS:   tmax_reg   <= pwdata[15:0];
				DBZ_OFS:    dbz_reg    <= pwdata[15:0];
				DBS_OFS:    dbs_reg    <= pwdata[15:0];
				FILT_OFS:   filt_reg   <= pwdata[15:0];
				FMIN_OFS:   fmin_reg   <= pwdata[15:0];
				FMAX_OFS:   fmax_reg   <= pwdata[15:0];
				default: ;
			endcase
		end
	end
	// ==========================================================
	// APB answer: zero wait states, error on unmapped address
	logic addr_ok;
	always_comb begin
		unique case (paddr)
			CTRL_OFS, STAT_OFS, HVEL_OFS, HACC_OFS, OFFS_OFS, STROKE_OFS,
			TMIN_OFS, TMAX_OFS, DBZ_OFS, DBS_OFS, FILT_OFS, FMIN_OFS,
			FMAX_OFS, POS_OFS, TGT_OFS, FBP_OFS: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !addr_ok;
			if (psel && !penable && !pwrite) begin
				unique case (paddr)
					CTRL_OFS:   prdata <= {24'h0, nofb_reg, absmv_reg, 3'h0, meth_reg};
					STAT_OFS:   prdata <= {26'h0, st_reg[5:1], referenced};
					HVEL_OFS:   prdata <= hvel_reg;
					HACC_OFS:   prdata <= hacc_reg;
					OFFS_OFS:   prdata <= offs_reg;
					STROKE_OFS: prdata <= stroke_reg;
					TMIN_OFS:   prdata <= {{16{tmin_reg[15]}}, tmin_reg};
					TMAX_OFS:   prdata <= {{16{tmax_reg[15]}}, tmax_reg};
					DBZ_OFS:    prdata <= {16'h0, dbz_reg};
					DBS_OFS:    prdata <= {16'h0, dbs_reg};
					FILT_OFS:   prdata <= {16'h0, filt_reg};
					FMIN_OFS:   prdata <= {{16{fmin_reg[15]}}, fmin_reg};
					FMAX_OFS:   prdata <= {{16{fmax_reg[15]}}, fmax_reg};
					POS_OFS:    prdata <= actual_position - zero_reg;
					TGT_OFS:    prdata <= tgt_pos_reg;
					FBP_OFS:    prdata <= fb_pos_reg;
					default:    prdata <= '0;
				endcase
			end
		end
	end
	// ==========================================================
	// Homing sequencer
	logic idx_d_reg, ref_sig, ref_d_reg, ref_fall, sw_dir_neg, idx_dir_neg, is_sw, is_idx;
	logic [2:0] meth_cur;
	// Method and start may share one write; the new method must steer that start
	assign meth_cur = (wr_ok && paddr == CTRL_OFS) ? pwdata[CTRL_METH_LSB +: 3] : meth_reg;
	assign is_sw  = meth_cur == HOME_NEGATIVE_SWITCH || meth_cur == HOME_POSITIVE_SWITCH;
	assign is_idx = meth_cur == HOME_INDEX_NEGATIVE_SEARCH
		|| meth_cur == HOME_INDEX_POSITIVE_SEARCH;
	assign sw_dir_neg  = meth_cur == HOME_NEGATIVE_SWITCH;
	assign idx_dir_neg = meth_cur == HOME_INDEX_NEGATIVE_SEARCH;
	assign ref_sig  = is_idx ? idx_s : (sw_dir_neg ? lim_neg_s : lim_pos_s);
	assign ref_fall = ref_d_reg && !ref_sig;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_d_reg <= 1'b0;
			idx_d_reg <= 1'b0;
		end else begin
			ref_d_reg <= ref_sig;
			idx_d_reg <= idx_s;
		end
	end
	logic signed [31:0] fb_home;
	assign fb_home = fb_pos_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg       <= ST_IDLE;
			zero_reg     <= '0;
			move_req     <= 1'b0;
			move_dir_neg <= 1'b0;
			stop_req     <= 1'b0;
			move_vel     <= '0;
			move_acc     <= '0;
		end else if (drive_error || !en_s) begin
			st_reg   <= ST_IDLE;
			move_req <= 1'b0;
			stop_req <= 1'b1;
		end else begin
			stop_req <= 1'b0;
			unique case (st_reg)
				ST_IDLE: if (start_pulse) begin
					move_vel <= hvel_reg;
					move_acc <= hacc_reg;
					if (is_sw || is_idx) begin
						move_req     <= 1'b1;
						move_dir_neg <= is_sw ? sw_dir_neg : idx_dir_neg;
						st_reg       <= ST_SEARCH;
					end else begin
						// Current or analogue: zero is fixed here, offset added
						zero_reg <= (meth_cur == HOME_ANALOG_ABSOLUTE)
							? actual_position - fb_home - offs_reg
							: actual_position - offs_reg;
						st_reg   <= ST_DONE;
					end
				end
				ST_SEARCH: if (is_idx && ref_fall) begin
					zero_reg <= actual_position - offs_reg;
					move_req <= 1'b0;
					stop_req <= 1'b1;
					st_reg   <= ST_SETTLE;
				end else if (is_sw && ref_sig) begin
					move_req <= 1'b0;
					stop_req <= 1'b1;
					st_reg   <= ST_BRAKE;
				end
				ST_BRAKE: if (axis_standstill) begin
					move_req     <= 1'b1;
					move_dir_neg <= !move_dir_neg;
					st_reg       <= ST_LEAVE;
				end
				ST_LEAVE: if (ref_fall) begin
					zero_reg <= actual_position - offs_reg;
					move_req <= 1'b0;
					stop_req <= 1'b1;
					st_reg   <= ST_SETTLE;
				end
				// Rest wherever the stop lands; no reversal back onto zero
				ST_SETTLE: if (axis_standstill) st_reg <= ST_DONE;
				ST_DONE: if (start_pulse) st_reg <= ST_IDLE;
				default: st_reg <= ST_IDLE;
			endcase
		end
	end
	// ==========================================================
	// Referenced flag and absolute move gate
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			referenced <= 1'b0;
		end else if (nofb_reg && (drive_error || !en_s)) begin
			referenced <= 1'b0;
		end else if (st_reg == ST_SETTLE && axis_standstill) begin
			referenced <= 1'b1;
		end else if (st_reg == ST_IDLE && start_pulse && !(is_sw || is_idx)) begin
			referenced <= 1'b1;
		end
	end
	// ==========================================================
	// Analogue target path: average, zero band, signal band, scale
	logic signed [15:0] tgt_avg, tgt_held_reg, tgt_use;
	hap_avg #(.W(16)) u_avg (
		.pclk       (pclk),
		.presetn    (presetn),
		.sample     (tgt_s),
		.win_ms     (filt_reg),
		.cyc_per_ms (CYC_PER_MS),
		.avg        (tgt_avg)
	);
	logic signed [16:0] tdiff;
	logic               in_zero_band;
	assign tdiff        = 17'(tgt_avg) - 17'(tgt_held_reg);
	assign in_zero_band = (tgt_avg <= $signed({1'b0, dbz_reg[14:0]}))
		&& (tgt_avg >= -$signed({1'b0, dbz_reg[14:0]}));
	assign tgt_use = in_zero_band ? 16'sh0 : tgt_held_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tgt_held_reg <= '0;
		end else if (tdiff > $signed({1'b0, dbs_reg}) || tdiff < -$signed({1'b0, dbs_reg})) begin
			tgt_held_reg <= tgt_avg;
		end
	end
	// Linear map; one divide per path, trading area for simplicity
	function automatic logic signed [31:0] scale(input logic signed [15:0] v,
		input logic signed [15:0] lo, input logic signed [15:0] hi,
		input logic signed [31:0] stroke);
		logic signed [63:0] num;
		logic signed [31:0] span;
		num  = 64'(v - lo) * 64'(stroke);
		span = 32'(hi - lo);
		if (span <= 0) span = 32'sh1;
		scale = 32'(num / 64'(span));
	endfunction
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tgt_pos_reg <= '0;
			fb_pos_reg  <= '0;
		end else begin
			tgt_pos_reg <= in_zero_band ? 32'sh0
				: scale(tgt_use, tmin_reg, tmax_reg, stroke_reg);
			fb_pos_reg  <= scale(fb_s, fmin_reg, fmax_reg, stroke_reg);
		end
	end
	// ==========================================================
	// Absolute moves, including return to zero, only once referenced
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			abs_move_req <= 1'b0;
			abs_target   <= '0;
		end else begin
			abs_move_req <= 1'b0;
			// A fault in this cycle clears referenced when nofb_reg is set; no move may slip out with it
			if (referenced && st_reg == ST_DONE && !drive_error && en_s) begin
				if (gozero_pulse) begin
					abs_move_req <= 1'b1;
					abs_target   <= zero_reg;
				end else if (absmv_reg && !in_zero_band) begin
					abs_move_req <= 1'b1;
					abs_target   <= zero_reg + tgt_pos_reg;
				end
			end
		end
	end
endmodule

/* File: bench/hap_chk.sv */
// Checker: assertions on the ports of hap_top
// Assumes: one pclk domain, presetn asynchronous and active low
`timescale 1ns/1ps
module hap_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic drive_enable_input,
	input wire logic positive_limit_input,
	input wire logic negative_limit_input,
	input wire logic drive_error,
	input wire logic axis_standstill,
	input wire logic move_req,
	input wire logic move_dir_neg,
	input wire logic stop_req,
	input wire logic abs_move_req,
	input wire logic referenced
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================================
	// Bus answer
	rdy_after_setup_a: assert property (psel && !penable |=> pready)
		else $error("no pready after setup");
	rdy_one_cycle_a: assert property (pready |=> !pready)
		else $error("pready held too long");
	err_needs_rdy_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	// ==========================================================
	// Homing and reference
	lim_stop_a: assert property (
		move_req && ($rose(negative_limit_input) && move_dir_neg
		|| $rose(positive_limit_input) && !move_dir_neg) |-> ##[1:6] stop_req)
		else $error("no stop at switch");
	start_still_a: assert property ($rose(move_req) |-> $past(axis_standstill))
		else $error("move began while axis moving");
	ref_at_rest_a: assert property ($rose(referenced) |-> $past(axis_standstill))
		else $error("referenced before standstill");
	err_clears_a: assert property (drive_error |-> ##[1:3] !referenced)
		else $error("referenced kept on error");
	en_clears_a: assert property ($fell(drive_enable_input) |-> ##[1:6] !referenced)
		else $error("referenced kept on disable");
	abs_gated_a: assert property (abs_move_req |-> referenced)
		else $error("absolute move while unreferenced");
	abs_pulse_a: assert property (abs_move_req |=> !abs_move_req)
		else $error("absolute move request held");
	ref_c: cover property ($rose(referenced));
	err_c: cover property (pslverr);
	rev_c: cover property (move_req && $changed(move_dir_neg));
endmodule

bind hap_top hap_chk u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
	.drive_enable_input, .positive_limit_input, .negative_limit_input, .drive_error,
	.axis_standstill, .move_req, .move_dir_neg, .stop_req, .abs_move_req, .referenced);

/* File: bench/hap_motor.sv */
// Partner: motor, encoder index and limit switches of one axis
// Assumes: one position unit per pclk while moving; switches at +/-LIM
`timescale 1ns/1ps
module hap_motor #(
	parameter int LIM = 300,
	parameter int IDX = 100,
	parameter int BRK = 6
) (
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          move_req,
	input  wire logic          move_dir_neg,
	input  wire logic          stop_req,
	output logic               positive_limit_input,
	output logic               negative_limit_input,
	output logic               encoder_index,
	output logic               axis_standstill,
	output logic signed [31:0] actual_position
);
	int   brk;
	logic dir;
	// ==========================================================
	// Motion: a stop coasts BRK cycles in place of a real ramp
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			brk             <= 0;
			dir             <= 1'b0;
			axis_standstill <= 1'b1;
			actual_position <= 32'sh0;
		end else begin
			if (stop_req && !axis_standstill && brk == 0)
				brk <= BRK;
			else if (brk > 0)
				brk <= brk - 1;
			if (brk == 0 && move_req)
				dir <= move_dir_neg;
			if (brk > 0 || (move_req && !stop_req))
				actual_position <= actual_position + ((brk > 0 ? dir : move_dir_neg) ? -1 : 1);
			axis_standstill <= !(brk > 1 || (move_req && !stop_req)
				|| (stop_req && !axis_standstill));
		end
	end
	// ==========================================================
	// Switch levels follow position, each on its own input
	assign negative_limit_input = actual_position <= -LIM;
	assign positive_limit_input = actual_position >= LIM;
	assign encoder_index        = actual_position >= IDX && actual_position < IDX + 4;
endmodule

/* File: bench/tb_top.sv */
// Testbench: register access and all homing methods against the motor model
// Assumes: hap_pkg, hap_top, hap_motor and hap_chk compiled first
`timescale 1ns/1ps
module tb_top;
	import hap_pkg::*;
	logic               pclk = 1'b0;
	logic               presetn = 1'b0;
	logic               psel = 1'b0;
	logic               penable = 1'b0;
	logic               pwrite = 1'b0;
	logic [11:0]        paddr = 12'h000;
	logic [31:0]        pwdata = 32'h0;
	logic               local_ui_sel = 1'b0;
	logic               fieldbus_active = 1'b0;
	logic               drive_enable_input = 1'b1;
	logic               drive_error = 1'b0;
	logic signed [15:0] target_analog_input = 16'sh0;
	logic signed [15:0] feedback_analog_input = 16'sh0;
	logic [31:0]        prdata, rd, move_vel, move_acc;
	logic               pready, pslverr, move_req, move_dir_neg, stop_req, abs_move_req;
	logic               positive_limit_input, negative_limit_input, encoder_index;
	logic               referenced, axis_standstill;
	logic signed [31:0] actual_position, abs_target;
	logic [33:0]        exp_q[$];
	logic [33:0]        note;
	int                 errors = 0;
	int                 num_checks = 0;
	int                 seed = 58;
	int                 absn = 0;
	int                 offs = 0;
	int                 n0;
	logic signed [31:0] abs_seen = 32'sh0;
	logic [11:0]        ra [12] = '{CTRL_OFS, HVEL_OFS, HACC_OFS, OFFS_OFS, STROKE_OFS,
		TMIN_OFS, TMAX_OFS, DBZ_OFS, DBS_OFS, FILT_OFS, FMIN_OFS, FMAX_OFS};
	logic [31:0]        rv [12] = '{32'h80, HVEL_RST, HACC_RST, 32'h0, STROKE_RST, 32'h0,
		{16'h0, TMAX_RST}, {16'h0, DBZ_RST}, {16'h0, DBS_RST}, {16'h0, FILT_RST}, 32'h0,
		{16'h0, FMAX_RST}};
	logic [2:0]         mo [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h0, 3'h5};

	always #2 pclk = ~pclk;
	hap_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .local_ui_sel,
		.prdata, .pready, .pslverr, .fieldbus_active, .drive_enable_input,
		.positive_limit_input, .negative_limit_input, .encoder_index, .drive_error,
		.axis_standstill, .actual_position, .target_analog_input, .feedback_analog_input,
		.move_req, .move_dir_neg, .stop_req, .move_vel, .move_acc, .abs_move_req,
		.abs_target, .referenced);
	hap_motor u_motor (.pclk, .presetn, .move_req, .move_dir_neg, .stop_req,
		.positive_limit_input, .negative_limit_input, .encoder_index, .axis_standstill,
		.actual_position);
	// ==========================================================
	// Analogue inputs: random noise only, the 10 ms averaging is too slow to judge here
	always @(posedge pclk) begin
		target_analog_input   <= 16'($random(seed) % 10000);
		feedback_analog_input <= 16'($random(seed) % 10000);
	end
	always @(posedge pclk) begin
		if (abs_move_req === 1'b1) begin
			absn++;
			abs_seen = abs_target;
		end
	end
	// ==========================================================
	// Monitor: oldest note against each bus answer
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1) begin
			note = exp_q.pop_front();
			chk("pslverr", 32'(note[32]), 32'(pslverr));
			if (note[33])
				chk("prdata", note[31:0], prdata);
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [33:0] nt);
		@(posedge pclk);
		exp_q.push_back(nt);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 34'h0);
	endtask
	task automatic rdx(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, {2'b10, e});
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic home(input logic [2:0] m);
		int   i, flips, stops;
		logic s, first;
		logic signed [31:0] z;
		flips = 0;
		stops = 0;
		first = 1'b1;
		drive_enable_input <= 1'b0;
		tick(8);
		chk("ref_off", 32'h0, 32'(referenced));
		drive_enable_input <= 1'b1;
		tick(4);
		wr(CTRL_OFS, 32'h90 | {29'h0, m});
		for (i = 0; i < 3000 && referenced !== 1'b1; i++) begin
			@(posedge pclk);
			if (move_req === 1'b1 && first) begin
				first = 1'b0;
				s = move_dir_neg;
				chk("dir", 32'(m == 1 || m == 3), 32'(s));
				chk("vel", HVEL_RST, move_vel);
				chk("acc", HVEL_RST * 8, move_acc);
			end else if (move_req === 1'b1 && move_dir_neg !== s)
				flips++;
			if (stop_req === 1'b1)
				stops++;
		end
		chk("referenced", 32'h1, 32'(referenced));
		if (m inside {[1:4]}) begin
			chk("reverse", 32'(m < 3), 32'(flips > 0));
			chk("stop", 32'h1, 32'(stops > 0));
		end
		tick(12);
		apb(1'b0, POS_OFS, 32'h0, 34'h0);
		z = actual_position - $signed(rd);
		i = (m == 1 || m == 4) ? $signed(rd) - offs : offs - $signed(rd);
		if (m == 0)
			chk("pos", offs, rd);
		else if (m != 5)
			chk("past_zero", 32'h1, 32'(i > 0 && i < 40));
		i = absn;
		wr(CTRL_OFS, 32'hA0);
		tick(6);
		chk("go_zero", i + 1, absn);
		chk("abs_target", z, abs_seen);
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		tick(10);
		presetn <= 1'b1;
		for (int k = 0; k < 12; k++)
			rdx(ra[k], rv[k]);
		apb(1'b0, 12'h040, 32'h0, {2'b01, 32'h0});
		wr(HACC_OFS, HVEL_RST * 8);
		wr(TMIN_OFS, 32'h0000_D8F0);
		fieldbus_active <= 1'b1;
		local_ui_sel    <= 1'b1;
		wr(OFFS_OFS, 32'h0000_0037);
		local_ui_sel <= 1'b0;
		rdx(OFFS_OFS, 32'h0);
		offs = 7;
		wr(OFFS_OFS, 32'h7);
		rdx(OFFS_OFS, 32'h7);
		for (int k = 0; k < 6; k++) begin
			if (k == 1) begin
				offs = 100;
				wr(OFFS_OFS, STROKE_RST);
			end
			home(mo[k]);
		end
		drive_error <= 1'b1;
		tick(4);
		chk("err_ref", 32'h0, 32'(referenced));
		drive_error <= 1'b0;
		n0 = absn;
		wr(CTRL_OFS, 32'hA0);
		tick(6);
		chk("gated", n0, absn);
		chk("pending", 32'h0, 32'(exp_q.size()));
		give_verdict();
	end
	initial begin
		// Whole run is under 2k cycles; the margin covers a slow design
		#160000;
		errors++;
		give_verdict();
	end
endmodule
